/* core/sspa_pkg.sv */
package sspa_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Addressing constants.
    localparam logic [3:0] ADDR_FIXED_HI  = 4'hA;     // Upper four address bits, 1010.
    localparam logic [6:0] BCAST_ADDR     = 7'h00;    // Shared write-only broadcast address.
    localparam int         EXT_ADDR_BIT   = 1;        // Extended bit position in configuration register four.
    localparam logic       EXT_ADDR_RESET = 1'b0;     // Extended bit value before the download latches it.
    localparam logic [2:0] LOW_GND_EXT0   = 3'h0;
    localparam logic [2:0] LOW_VDD_EXT0   = 3'h1;
    localparam logic [2:0] LOW_NC_EXT0    = 3'h4;
    localparam logic [2:0] LOW_GND_EXT1   = 3'h2;
    localparam logic [2:0] LOW_VDD_EXT1   = 3'h3;
    localparam logic [2:0] LOW_NC_EXT1    = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // Address map and framing.
    localparam logic [7:0]  VOL_LAST      = 8'h7F;
    localparam logic [7:0]  NV_HI_FIRST   = 8'h80;
    localparam logic [7:0]  NV_HI_LAST    = 8'h81;
    localparam logic [15:0] NV_FIRST      = 16'h8000;
    localparam logic [15:0] NV_LAST       = 16'h813F;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic        DIR_READ      = 1'b1;
    localparam int          BUF_DEPTH     = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [1:0] {
        SSPA_REG_VOLATILE,
        SSPA_REG_NONVOL_HI,
        SSPA_REG_NONVOL_LO,
        SSPA_REG_INSTR
    } sspa_region_t;

    typedef struct packed {
        logic [7:0]   data;
        logic         first;
        logic         bcast;
        sspa_region_t region;
        logic         in_range;
    } sspa_word_t;

    typedef struct packed {
        logic       power_on;
        logic [1:0] mains;
    } sspa_path_t;

    typedef enum logic [2:0] {
        SSPA_IDLE,
        SSPA_SHIFT_IN,
        SSPA_ACK_OUT,
        SSPA_SHIFT_OUT,
        SSPA_ACK_IN
    } sspa_state_t;

    typedef struct packed {
        logic        scl_m;
        logic        scl_s;
        logic        scl_p;
        logic        sda_m;
        logic        sda_s;
        logic        sda_p;
        logic        hi_m;
        logic        hi_s;
        logic        lo_m;
        logic        lo_s;
        sspa_path_t  pin_m;
        sspa_path_t  pin_s;
        sspa_state_t st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        addr_phase;
        logic        is_read;
        logic        bcast;
        logic        ack;
        logic        first;
        logic        second;
        logic [7:0]  cmd;
        logic        ext;
        logic        ext_done;
        logic        bias_on;
        logic        sda_oe;
        logic        sda_o;
        logic        push;
        sspa_word_t  word;
        logic        tx_taken;
        logic        busy;
        sspa_path_t  down;
        sspa_path_t  readback;
    } sspa_core_t;

endpackage : sspa_pkg

/* core/sspa_buffer.sv */
module sspa_buffer (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire sspa_pkg::sspa_word_t in_word,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output sspa_pkg::sspa_word_t    out_word
);
    import sspa_pkg::*;

    localparam int PW = $clog2(BUF_DEPTH);

    typedef struct packed {
        sspa_word_t [BUF_DEPTH-1:0] mem;
        logic [PW-1:0]              wp;
        logic [PW-1:0]              rp;
        logic [PW:0]                cnt;
    } sspa_buf_t;

    sspa_buf_t r;
    sspa_buf_t next_r;
    logic      wr;
    logic      rd;

    ////////////////////////////////////////////////////////////////////////////////
    // Full and empty come straight from the count, so both flags are exact.
    always_comb begin
        next_r = r;
        wr     = in_valid && (r.cnt != (PW+1)'(BUF_DEPTH));
        rd     = out_ready && (r.cnt != '0);
        if (wr) begin
            next_r.mem[r.wp] = in_word;
            next_r.wp        = r.wp + 1'b1;
        end
        if (rd) begin
            next_r.rp = r.rp + 1'b1;
        end
        if (wr && !rd) begin
            next_r.cnt = r.cnt + 1'b1;
        end else if (rd && !wr) begin
            next_r.cnt = r.cnt - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign in_ready  = (r.cnt != (PW+1)'(BUF_DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_word  = r.mem[r.rp];

endmodule : sspa_buffer

/* core/sspa_slave.sv */
module sspa_slave (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe,
    input  wire logic                 address_select_pin_high,
    input  wire logic                 address_select_pin_low,
    output logic                      address_select_pin_bias,
    input  wire logic [7:0]           configuration_register_four,
    input  wire logic                 nv_download_done,
    output logic                      extended_address_bit,
    output logic                      rx_valid,
    input  wire logic                 rx_ready,
    output sspa_pkg::sspa_word_t      rx_word,
    input  wire logic [7:0]           tx_byte,
    output logic                      tx_taken,
    output logic                      busy,
    input  wire sspa_pkg::sspa_path_t pin_signals,
    input  wire sspa_pkg::sspa_path_t break_enable,
    input  wire sspa_pkg::sspa_path_t uc_signals,
    output sspa_pkg::sspa_path_t      downstream,
    output sspa_pkg::sspa_path_t      readback
);
    import sspa_pkg::*;

    sspa_core_t r;
    sspa_core_t next_r;
    logic       buf_ready;
    logic       start_ev;
    logic       stop_ev;
    logic       rise;
    logic       fall;
    logic [6:0] own_addr;
    logic       own_hit;
    logic       bcast_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Maps the three-level pin and the extended bit onto the low address bits.
    function automatic logic [2:0] sspa_low_bits(input logic hi, input logic lo, input logic ext);
        logic [2:0] v;
        v = ext ? LOW_NC_EXT1 : LOW_NC_EXT0;
        if (hi) begin
            v = ext ? LOW_VDD_EXT1 : LOW_VDD_EXT0;
        end else if (lo) begin
            v = ext ? LOW_GND_EXT1 : LOW_GND_EXT0;
        end
        return v;
    endfunction : sspa_low_bits

    // Classifies a command byte by the region it selects.
    function automatic sspa_region_t sspa_cmd_region(input logic [7:0] c);
        sspa_region_t g;
        g = SSPA_REG_INSTR;
        if (c <= VOL_LAST) begin
            g = SSPA_REG_VOLATILE;
        end else if (c >= NV_HI_FIRST && c <= NV_HI_LAST) begin
            g = SSPA_REG_NONVOL_HI;
        end
        return g;
    endfunction : sspa_cmd_region

    ////////////////////////////////////////////////////////////////////////////////
    // Bus events come only from the second and third stages of the line samplers.
    // The bus clock is several of our periods long, so a two-stage delay costs nothing.
    assign rise     = r.scl_s && !r.scl_p;
    assign fall     = !r.scl_s && r.scl_p;
    assign start_ev = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
    assign stop_ev  = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;

    // Address comparison, with the pin sampled continuously.
    assign own_addr  = {ADDR_FIXED_HI, sspa_low_bits(r.hi_s, r.lo_s, r.ext)};
    assign own_hit   = (r.sh[7:1] == own_addr);
    assign bcast_hit = (r.sh[7:1] == BCAST_ADDR) && (r.sh[0] != DIR_READ);

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole port.
    always_comb begin
        next_r          = r;
        next_r.push     = 1'b0;
        next_r.tx_taken = 1'b0;
        next_r.sda_o    = 1'b0;    // The line is only ever pulled low, never high.

        // Two-stage samplers on every asynchronous input, then one history stage on the clock and data lines.
        next_r.scl_m = scl_in;
        next_r.scl_s = r.scl_m;
        next_r.scl_p = r.scl_s;
        next_r.sda_m = sda_in;
        next_r.sda_s = r.sda_m;
        next_r.sda_p = r.sda_s;
        next_r.hi_m  = address_select_pin_high;
        next_r.hi_s  = r.hi_m;
        next_r.lo_m  = address_select_pin_low;
        next_r.lo_s  = r.lo_m;
        next_r.pin_m = pin_signals;
        next_r.pin_s = r.pin_m;

        // The extended bit is taken once, at the first download after reset.
        if (nv_download_done && !r.ext_done) begin
            next_r.ext      = configuration_register_four[EXT_ADDR_BIT];
            next_r.ext_done = 1'b1;
        end

        // The original signals stay visible ahead of the break.
        next_r.readback = r.pin_s;
        next_r.down.power_on = break_enable.power_on ? uc_signals.power_on : r.pin_s.power_on;
        for (int i = 0; i < 2; i++) begin
            next_r.down.mains[i] = break_enable.mains[i] ? uc_signals.mains[i] : r.pin_s.mains[i];
        end

        // Frame sequencer: the clock pin is an input only.
        case (r.st)
            SSPA_IDLE: begin
                next_r.sda_oe = 1'b0;
            end

            SSPA_SHIFT_IN: begin
                // Data is taken on the rising edge, when the line is stable.
                if (rise && r.cnt < BITS_PER_BYTE) begin
                    next_r.sh  = {r.sh[6:0], r.sda_s};
                    next_r.cnt = r.cnt + 4'h1;
                end
                if (fall && r.cnt == BITS_PER_BYTE) begin
                    next_r.st = SSPA_ACK_OUT;
                    if (r.addr_phase) begin
                        next_r.ack     = own_hit || bcast_hit;
                        next_r.is_read = (r.sh[0] == DIR_READ);
                        next_r.bcast   = bcast_hit && !own_hit;
                        next_r.first   = 1'b1;
                        next_r.second  = 1'b0;
                        if (own_hit || bcast_hit) begin
                            next_r.bias_on = 1'b0;
                        end
                    end else begin
                        // A word is acknowledged only if the buffer can take it; a refused word
                        // shows as no acknowledge, so the master learns of the stall.
                        next_r.ack            = buf_ready;
                        next_r.push           = buf_ready;
                        next_r.word.data      = r.sh;
                        next_r.word.first     = r.first;
                        next_r.word.bcast     = r.bcast;
                        next_r.word.region    = sspa_cmd_region(r.first ? r.sh : r.cmd);
                        next_r.word.in_range  = (sspa_cmd_region(r.first ? r.sh : r.cmd) != SSPA_REG_INSTR);
                        if (r.second && sspa_cmd_region(r.cmd) == SSPA_REG_NONVOL_HI) begin
                            next_r.word.region   = SSPA_REG_NONVOL_LO;
                            next_r.word.in_range = ({r.cmd, r.sh} >= NV_FIRST) && ({r.cmd, r.sh} <= NV_LAST);
                        end
                        if (buf_ready) begin
                            if (r.first) begin
                                next_r.cmd = r.sh;
                            end
                            next_r.second = r.first;
                            next_r.first  = 1'b0;
                        end
                    end
                    next_r.sda_oe = (r.addr_phase ? (own_hit || bcast_hit) : buf_ready);
                end
            end

            SSPA_ACK_OUT: begin
                // Acknowledge held through the ninth clock, released at its falling edge.
                if (fall) begin
                    next_r.addr_phase = 1'b0;
                    next_r.cnt        = 4'h0;
                    next_r.sda_oe     = 1'b0;
                    if (!r.ack) begin
                        next_r.st = SSPA_IDLE;
                    end else if (r.is_read) begin
                        // The first read bit goes out in this same low phase.
                        next_r.st       = SSPA_SHIFT_OUT;
                        next_r.sh       = tx_byte;
                        next_r.tx_taken = 1'b1;
                        next_r.sda_oe   = !tx_byte[7];
                    end else begin
                        next_r.st = SSPA_SHIFT_IN;
                    end
                end
            end

            SSPA_SHIFT_OUT: begin
                if (rise) begin
                    next_r.cnt = r.cnt + 4'h1;
                end
                if (fall) begin
                    if (r.cnt == BITS_PER_BYTE) begin
                        next_r.st     = SSPA_ACK_IN;
                        next_r.sda_oe = 1'b0;
                    end else begin
                        next_r.sh     = {r.sh[6:0], 1'b0};
                        next_r.sda_oe = !r.sh[6];
                    end
                end
            end

            SSPA_ACK_IN: begin
                // A released line at the ninth clock ends the read.
                if (rise) begin
                    next_r.ack = !r.sda_s;
                end
                if (fall) begin
                    next_r.cnt = 4'h0;
                    if (r.ack) begin
                        next_r.st       = SSPA_SHIFT_OUT;
                        next_r.sh       = tx_byte;
                        next_r.tx_taken = 1'b1;
                        next_r.sda_oe   = !tx_byte[7];
                    end else begin
                        next_r.st = SSPA_IDLE;
                    end
                end
            end

            default: begin
                next_r.st     = SSPA_IDLE;
                next_r.sda_oe = 1'b0;
            end
        endcase

        // Start and repeated start win over anything the sequencer was doing.
        if (start_ev) begin
            next_r.st         = SSPA_SHIFT_IN;
            next_r.addr_phase = 1'b1;
            next_r.cnt        = 4'h0;
            next_r.sda_oe     = 1'b0;
            next_r.ack        = 1'b0;
        end else if (stop_ev) begin
            next_r.st     = SSPA_IDLE;
            next_r.sda_oe = 1'b0;
        end

        next_r.busy = (next_r.st != SSPA_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; the pin bias is on from reset until first addressed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r         <= '0;
            r.ext     <= EXT_ADDR_RESET;
            r.bias_on <= 1'b1;
            r.scl_m   <= 1'b1;
            r.scl_s   <= 1'b1;
            r.scl_p   <= 1'b1;
            r.sda_m   <= 1'b1;
            r.sda_s   <= 1'b1;
            r.sda_p   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Received words pass a two-entry buffer so a stalled consumer loses nothing.
    sspa_buffer u_buffer (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (r.push),
        .in_ready  (buf_ready),
        .in_word   (r.word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_word  (rx_word)
    );

    // Outputs straight from the state register.
    assign sda_out                 = r.sda_o;
    assign sda_oe                  = r.sda_oe;
    assign address_select_pin_bias = r.bias_on;
    assign extended_address_bit    = r.ext;
    assign tx_taken                = r.tx_taken;
    assign busy                    = r.busy;
    assign downstream              = r.down;
    assign readback                = r.readback;

endmodule : sspa_slave

/* dv/sspa_chk.sv */
module sspa_chk (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 scl_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe,
    input wire logic                 address_select_pin_bias,
    input wire logic                 nv_download_done,
    input wire logic                 extended_address_bit,
    input wire logic                 rx_valid,
    input wire logic                 rx_ready,
    input wire sspa_pkg::sspa_word_t rx_word,
    input wire logic                 busy,
    input wire sspa_pkg::sspa_path_t pin_signals,
    input wire sspa_pkg::sspa_path_t break_enable,
    input wire sspa_pkg::sspa_path_t uc_signals,
    input wire sspa_pkg::sspa_path_t downstream,
    input wire sspa_pkg::sspa_path_t readback
);
    import sspa_pkg::*;

    // One clock domain; a reset abandons every attempt in flight.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // The data line is only ever pulled low, and only by a frame in progress.
    odrain_a: assert property (sda_oe |-> !sda_out) else $error("data line driven high");
    oe_busy_a: assert property (sda_oe |-> busy) else $error("data line pulled while idle");
    // The pull may only move while the bus clock is low, so a high phase never sees a change.
    oe_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("pull moved in high");
    // The extended bit is latched by the download and by nothing else.
    ext_latch_a: assert property ($changed(extended_address_bit) |-> $past(nv_download_done)) else $error("ext moved");
    // Bias drops only while addressed, and once dropped it stays off until reset.
    bias_keep_a: assert property (!address_select_pin_bias |=> !address_select_pin_bias) else $error("bias back on");
    bias_match_a: assert property ($fell(address_select_pin_bias) |-> busy) else $error("bias dropped idle");
    // A stalled word must stand unchanged, since the consumer may look at it late.
    rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word)) else $error("word lost");
    // Broken paths follow the microcontroller one edge later; readback follows the pin.
    brk_uc_a: assert property (break_enable == 3'h7 |=> downstream == $past(uc_signals)) else $error("break");
    rb_pin_a: assert property ($stable(pin_signals) [*6] |-> readback == pin_signals) else $error("readback");

    cov_ack_c: cover property ($rose(sda_oe));
    cov_stall_c: cover property (rx_valid && !rx_ready);
    cov_bias_c: cover property ($fell(address_select_pin_bias));
endmodule : sspa_chk

bind sspa_slave sspa_chk u_chk (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin_bias(address_select_pin_bias), .nv_download_done(nv_download_done),
    .extended_address_bit(extended_address_bit), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_word(rx_word), .busy(busy), .pin_signals(pin_signals), .break_enable(break_enable),
    .uc_signals(uc_signals), .downstream(downstream), .readback(readback)
);

/* dv/sspa_master.sv */
module sspa_master (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // Both lines rest released; the bus clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Waits whole block cycles, landing just after an edge.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    // One bus clock of 320 ns; data moves a cycle after the fall, never while high.
    task automatic bit_io(input logic b, output logic r);
        step(1);
        sda = b;
        step(3);
        scl = 1'b1;
        step(4);
        r = sda_wire;
        scl = 1'b0;
    endtask : bit_io

    // Start or repeated start: data falls while the clock is high.
    task automatic start;
        step(1);
        sda = 1'b1;
        step(3);
        scl = 1'b1;
        step(4);
        sda = 1'b0;
        step(4);
        scl = 1'b0;
    endtask : start

    // Stop: data rises while the clock is high.
    task automatic stop;
        step(1);
        sda = 1'b0;
        step(3);
        scl = 1'b1;
        step(4);
        sda = 1'b1;
        step(4);
    endtask : stop

    // Eight bits, most significant first, then the slave's acknowledge.
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte

    // Reads eight bits; a released ninth bit tells the slave the read is over.
    task automatic rbyte(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(!ack, r);
    endtask : rbyte
endmodule : sspa_master

/* dv/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sspa_pkg::*;

    logic       clk, rst_n, scl, sda_m, pin_hi, pin_lo, bias, ext, nv_done;
    logic       rx_valid, rx_ready, tx_taken, busy, sda_out, sda_oe;
    logic [7:0] cfg4, tx_byte, d;
    logic [6:0] own;
    sspa_word_t rx_word;
    sspa_path_t pin_sig, brk, uc, down, rb;
    int         n_errors, total_checks, cycles;
    sspa_word_t exp_q[$];
    logic [7:0] tx_q[$];
    logic [2:0] lo_tab [2][3] = '{'{3'h0, 3'h1, 3'h4}, '{3'h2, 3'h3, 3'h5}};
    wire        sda_wire = sda_m & !sda_oe;

    sspa_master u_master (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(sda_m));
    sspa_slave dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_select_pin_high(pin_hi), .address_select_pin_low(pin_lo), .address_select_pin_bias(bias),
        .configuration_register_four(cfg4), .nv_download_done(nv_done), .extended_address_bit(ext),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .tx_byte(tx_byte), .tx_taken(tx_taken),
        .busy(busy), .pin_signals(pin_sig), .break_enable(brk), .uc_signals(uc), .downstream(down), .readback(rb)
    );

    // Free-running block clock, 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic sspa_word_t w(logic [7:0] v, logic f, logic b, sspa_region_t r, logic ir);
        return '{v, f, b, r, ir};
    endfunction : w

    // Sends a byte and compares the acknowledge against the expected one.
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_master.wbyte(b, a);
        chk(16'(a), 16'(exp_ack), "ack");
    endtask : tx

    // Expects a byte to leave the buffer, then sends it with an acknowledge expected.
    task automatic txw(input logic [7:0] b, input logic f, input sspa_region_t r, input logic ir);
        exp_q.push_back(w(b, f, 1'b0, r, ir));
        tx(b, 1'b1);
    endtask : txw

    // A write frame of one volatile command, which is left out when the address is refused.
    task automatic poke(input logic [6:0] a, input logic ok, input logic bc);
        logic [7:0] c;
        c = 8'($urandom) & 8'h7F;
        u_master.start();
        tx({a, 1'b0}, ok);
        if (ok) begin
            exp_q.push_back(w(c, 1'b1, bc, SSPA_REG_VOLATILE, 1'b1));
            tx(c, 1'b1);
        end
        u_master.stop();
        chk(16'(busy), 16'h0, "idle after stop");
    endtask : poke

    // Reset, then two downloads; only the first may latch the extended bit.
    task automatic boot(input logic e);
        rst_n = 1'b0;
        cfg4 = (8'($urandom) & 8'hFD) | {6'h0, e, 1'b0};
        repeat (3) @(posedge clk);
        #2;
        rst_n = 1'b1;
        chk(16'(ext), 16'h0, "ext default");
        chk(16'(bias), 16'h1, "bias on");
        for (int k = 0; k < 2; k++) begin
            u_master.step(2);
            nv_done = 1'b1;
            u_master.step(1);
            nv_done = 1'b0;
            cfg4[1] = ~e;
        end
        chk(16'(ext), 16'(e), "ext latched");
    endtask : boot

    // Words leaving the buffer are matched against the oldest note.
    always @(posedge clk) begin
        if (rst_n && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) chk(16'(rx_word), 16'hFFFF, "stray word");
            else chk(16'(rx_word), 16'(exp_q.pop_front()), "rx word");
        end
    end

    // A taken byte is noted and replaced, so the next read byte is always ready.
    always @(posedge clk) begin
        if (tx_taken === 1'b1) begin
            tx_q.push_back(tx_byte);
            tx_byte <= 8'($urandom);
        end
    end

    // Cuts a hang short well above the few thousand cycles the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h99CF4D1F));
        {rst_n, pin_hi, pin_lo, nv_done, cfg4, pin_sig, brk, uc} = '0;
        rx_ready = 1'b1;
        tx_byte = 8'($urandom);
        // Every pin level with both settings of the extended bit.
        for (int e = 0; e < 2; e++) begin
            boot(e[0]);
            for (int p = 0; p < 3; p++) begin
                pin_hi = (p == 1);
                pin_lo = (p == 0);
                own = {4'hA, lo_tab[e][p]};
                poke({4'h5, own[2:0]}, 1'b0, 1'b0);
                poke({own[6:3], own[2:0] ^ 3'h1}, 1'b0, 1'b0);
                poke(own, 1'b1, 1'b0);
                chk(16'(bias), 16'h0, "bias off");
            end
        end
        $display("test addressing done");
        poke(BCAST_ADDR, 1'b1, 1'b1);
        u_master.start();
        tx({BCAST_ADDR, 1'b1}, 1'b0);
        u_master.stop();
        $display("test broadcast done");
        // Stalled consumer: two words fit, the third byte is refused.
        rx_ready = 1'b0;
        u_master.start();
        tx({own, 1'b0}, 1'b1);
        txw(8'h81, 1'b1, SSPA_REG_NONVOL_HI, 1'b1);
        txw(8'h3F, 1'b0, SSPA_REG_NONVOL_LO, 1'b1);
        tx(8'h55, 1'b0);
        u_master.stop();
        chk(16'(rx_valid), 16'h1, "held");
        rx_ready = 1'b1;
        u_master.step(4);
        chk(16'(rx_valid), 16'h0, "drained");
        $display("test buffer done");
        // Out of range address, an instruction, then a read, chained by repeated starts.
        u_master.start();
        tx({own, 1'b0}, 1'b1);
        txw(8'h81, 1'b1, SSPA_REG_NONVOL_HI, 1'b1);
        txw(8'h40, 1'b0, SSPA_REG_NONVOL_LO, 1'b0);
        u_master.start();
        tx({own, 1'b0}, 1'b1);
        txw(8'hA0, 1'b1, SSPA_REG_INSTR, 1'b0);
        u_master.start();
        tx({own, 1'b1}, 1'b1);
        for (int k = 0; k < 2; k++) begin
            u_master.rbyte(d, k == 0);
            chk(16'(d), 16'(tx_q.pop_front()), "read byte");
        end
        u_master.stop();
        chk(16'(tx_q.size()), 16'h0, "no extra load");
        $display("test read done");
        // Random path settings, the first with every path broken.
        for (int k = 0; k < 8; k++) begin
            pin_sig = 3'($urandom);
            uc = 3'($urandom);
            brk = (k == 0) ? 3'h7 : 3'($urandom);
            u_master.step(6);
            chk(16'(down), 16'((brk & uc) | (~brk & pin_sig)), "downstream");
            chk(16'(rb), 16'(pin_sig), "readback");
        end
        $display("test paths done");
        end_sim();
    end
endmodule : tb
